// [verilog/asq_pkg.sv]
package asq_pkg;

   // Register bus geometry
   localparam int            APB_AW        = 12;
   localparam int            APB_DW        = 32;

   // Control register indices as printed; byte address is four times the index
   localparam logic [11:0]   CTL0_IDX      = 12'h065;
   localparam logic [11:0]   CTL1_IDX      = 12'h1E5;
   localparam logic [11:0]   CTL0_ADDR     = {CTL0_IDX[9:0], 2'b00};
   localparam logic [11:0]   CTL1_ADDR     = {CTL1_IDX[9:0], 2'b00};

   // Status, interrupt and result windows
   localparam logic [11:0]   STAT0_ADDR    = 12'h800;
   localparam logic [11:0]   STAT1_ADDR    = 12'h804;
   localparam logic [11:0]   IRQ_STAT_ADDR = 12'h808;
   localparam logic [11:0]   IRQ_MASK_ADDR = 12'h80C;
   localparam logic [11:0]   RES0_BASE     = 12'h900;
   localparam logic [11:0]   RES1_BASE     = 12'h940;
   localparam int            RES_WIN_LSB   = 5;

   // Control register fields
   localparam int            CTL_W         = 7;
   localparam int            CTL_EIGHT_BIT = 6;
   localparam int            CTL_SCAN_BIT  = 5;
   localparam int            CTL_MULTICHANNEL_ENABLE_BIT  = 4;
   localparam int            CTL_CH3_BIT   = 3;
   localparam int            CTL_CH2_BIT   = 2;
   localparam logic [6:0]    CTL_RST       = 7'h00;

   // Status register layout: completion flag above the per-slot flags
   localparam int            STAT_SEQ_BIT  = 8;
   localparam int            NUM_SLOTS     = 8;
   localparam int            SLOT_W        = 3;
   localparam logic [2:0]    LAST_FOUR     = 3'h3;
   localparam logic [2:0]    LAST_EIGHT    = 3'h7;

   // Result width and interrupt bits
   localparam int            RES_W         = 10;
   localparam int            CHAN_W        = 4;
   localparam int            NUM_CONV      = 2;
   localparam logic [1:0]    IRQ_RST       = 2'h0;

   typedef enum logic [1:0] {ASQ_IDLE, ASQ_REQ, ASQ_WAIT} asq_state_t;

endpackage

// [verilog/asq_seq_if.sv]
`timescale 1ns/100ps
interface asq_seq_if;
   import asq_pkg::*;
   logic                      wr;
   logic [CTL_W-1:0]          wdata;
   logic [CTL_W-1:0]          ctrl;
   logic                      sequence_complete_flag;
   logic [NUM_SLOTS-1:0]      ccf;
   logic                      done;
   logic [SLOT_W-1:0]         rd_idx;
   logic [RES_W-1:0]          rd_data;

   modport top (output wr, output wdata, output rd_idx,
                input ctrl, input sequence_complete_flag, input ccf, input done, input rd_data);
   modport seq (input wr, input wdata, input rd_idx,
                output ctrl, output sequence_complete_flag, output ccf, output done, output rd_data);
endinterface

// [verilog/asq_sequencer.sv]
`timescale 1ns/100ps
module asq_sequencer
   import asq_pkg::*;
(
   input  wire logic              i_clk,
   input  wire logic              i_sys_rst,
   asq_seq_if.seq                 bus,
   output logic                   o_req,
   output logic [CHAN_W-1:0]      o_chan,
   input  wire logic              i_done,
   input  wire logic [RES_W-1:0]  i_data
);

   asq_state_t            state_ff, nxt_state;
   logic [SLOT_W-1:0]     cnt_ff, nxt_cnt;
   logic [CTL_W-1:0]      ctrl_ff, nxt_ctrl;
   logic                  scf_ff, nxt_scf;
   logic [NUM_SLOTS-1:0]  ccf_ff, nxt_ccf;
   logic [RES_W-1:0]      res_ff [NUM_SLOTS];
   logic [RES_W-1:0]      nxt_res [NUM_SLOTS];
   logic                  req_ff, nxt_req;
   logic [CHAN_W-1:0]     chan_ff, nxt_chan;
   logic                  done_ff, nxt_done;
   logic [SLOT_W-1:0]     last_slot;
   logic [CHAN_W-1:0]     chan_sel;

   // Sequence length and channel for the current slot
   always_comb begin
      last_slot = ctrl_ff[CTL_EIGHT_BIT] ? LAST_EIGHT : LAST_FOUR;
      if (!ctrl_ff[CTL_MULTICHANNEL_ENABLE_BIT]) begin
         chan_sel = ctrl_ff[CHAN_W-1:0];
      end else if (ctrl_ff[CTL_EIGHT_BIT]) begin
         chan_sel = {ctrl_ff[CTL_CH3_BIT], cnt_ff};
      end else begin
         // Codes 12..14 select the references and their midpoint
         chan_sel = {ctrl_ff[CTL_CH3_BIT:CTL_CH2_BIT], cnt_ff[1:0]};
      end
   end

   // Sequencer next state; a control write overrides any step in flight
   always_comb begin
      nxt_state = state_ff;
      nxt_cnt   = cnt_ff;
      nxt_ctrl  = ctrl_ff;
      nxt_scf   = scf_ff;
      nxt_ccf   = ccf_ff;
      nxt_res   = res_ff;
      nxt_req   = 1'b0;
      nxt_chan  = chan_ff;
      nxt_done  = 1'b0;
      if (bus.wr) begin
         nxt_ctrl  = bus.wdata;
         nxt_scf   = 1'b0;
         nxt_ccf   = '0;
         nxt_cnt   = '0;
         nxt_state = ASQ_REQ;
      end else begin
         unique case (state_ff)
            ASQ_IDLE: begin
            end
            ASQ_REQ: begin
               nxt_req   = 1'b1;
               nxt_chan  = chan_sel;
               nxt_state = ASQ_WAIT;
            end
            ASQ_WAIT: begin
               if (i_done) begin
                  nxt_res[cnt_ff] = i_data;
                  nxt_ccf[cnt_ff] = 1'b1;
                  if (cnt_ff == last_slot) begin
                     nxt_scf   = 1'b1;
                     nxt_done  = 1'b1;
                     nxt_cnt   = '0;
                     // Scan restarts at once and overwrites older results
                     nxt_state = ctrl_ff[CTL_SCAN_BIT] ? ASQ_REQ : ASQ_IDLE;
                  end else begin
                     nxt_cnt   = cnt_ff + 3'h1;
                     nxt_state = ASQ_REQ;
                  end
               end
            end
         endcase
      end
   end

   // Sequencer registers
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         state_ff <= ASQ_IDLE;
         cnt_ff   <= '0;
         ctrl_ff  <= CTL_RST;
         scf_ff   <= 1'b0;
         ccf_ff   <= '0;
         req_ff   <= 1'b0;
         chan_ff  <= '0;
         done_ff  <= 1'b0;
         for (int i = 0; i < NUM_SLOTS; i++) begin
            res_ff[i] <= '0;
         end
      end else begin
         state_ff <= nxt_state;
         cnt_ff   <= nxt_cnt;
         ctrl_ff  <= nxt_ctrl;
         scf_ff   <= nxt_scf;
         ccf_ff   <= nxt_ccf;
         req_ff   <= nxt_req;
         chan_ff  <= nxt_chan;
         done_ff  <= nxt_done;
         res_ff   <= nxt_res;
      end
   end

   // Status and result read-back
   assign bus.ctrl    = ctrl_ff;
   assign bus.sequence_complete_flag     = scf_ff;
   assign bus.ccf     = ccf_ff;
   assign bus.done    = done_ff;
   assign bus.rd_data = res_ff[bus.rd_idx];
   assign o_req       = req_ff;
   assign o_chan      = chan_ff;

endmodule // asq_sequencer

// [verilog/asq_top.sv]
`timescale 1ns/100ps
module asq_top
   import asq_pkg::*;
(
   input  wire logic               i_clk,
   input  wire logic               i_sys_rst,
   input  wire logic               i_psel,
   input  wire logic               i_penable,
   input  wire logic               i_pwrite,
   input  wire logic [APB_AW-1:0]  i_paddr,
   input  wire logic [APB_DW-1:0]  i_pwdata,
   input  wire logic [3:0]         i_pstrb,
   output logic [APB_DW-1:0]       o_prdata,
   output logic                    o_pready,
   output logic                    o_pslverr,
   output logic                    o_irq,
   output logic                    o_conv0_req,
   output logic [CHAN_W-1:0]       o_conv0_chan,
   input  wire logic               i_conv0_done,
   input  wire logic [RES_W-1:0]   i_conv0_data,
   output logic                    o_conv1_req,
   output logic [CHAN_W-1:0]       o_conv1_chan,
   input  wire logic               i_conv1_done,
   input  wire logic [RES_W-1:0]   i_conv1_data
);

   asq_seq_if u_if0 ();
   asq_seq_if u_if1 ();

   logic [APB_DW-1:0]    prdata_ff, nxt_prdata;
   logic                 pready_ff, nxt_pready;
   logic                 pslverr_ff, nxt_pslverr;
   logic [NUM_CONV-1:0]  irq_stat_ff, nxt_irq_stat;
   logic [NUM_CONV-1:0]  irq_mask_ff, nxt_irq_mask;
   logic                 irq_ff, nxt_irq;
   logic                 access;
   logic                 wr_access;
   logic                 lane0;
   logic                 mapped;
   logic [APB_DW-1:0]    rd_value;
   logic [NUM_CONV-1:0]  seq_done;

   // Access phase completes on the second cycle, when ready is already high
   assign access    = i_psel & i_penable & pready_ff;
   assign wr_access = access & i_pwrite;
   assign lane0     = i_pstrb[0];
   assign seq_done  = {u_if1.done, u_if0.done};

   // Control writes and result slot selection toward both sequencers
   assign u_if0.wr     = wr_access & lane0 & (i_paddr == CTL0_ADDR);
   assign u_if1.wr     = wr_access & lane0 & (i_paddr == CTL1_ADDR);
   assign u_if0.wdata  = i_pwdata[CTL_W-1:0];
   assign u_if1.wdata  = i_pwdata[CTL_W-1:0];
   assign u_if0.rd_idx = i_paddr[RES_WIN_LSB-1:2];
   assign u_if1.rd_idx = i_paddr[RES_WIN_LSB-1:2];

   // Read mux; unmapped addresses answer with an error and zero data
   always_comb begin
      rd_value = '0;
      mapped   = 1'b1;
      if (i_paddr == CTL0_ADDR) begin
         rd_value[CTL_W-1:0] = u_if0.ctrl;
      end else if (i_paddr == CTL1_ADDR) begin
         rd_value[CTL_W-1:0] = u_if1.ctrl;
      end else if (i_paddr == STAT0_ADDR) begin
         rd_value[STAT_SEQ_BIT]     = u_if0.sequence_complete_flag;
         rd_value[NUM_SLOTS-1:0]    = u_if0.ccf;
      end else if (i_paddr == STAT1_ADDR) begin
         rd_value[STAT_SEQ_BIT]     = u_if1.sequence_complete_flag;
         rd_value[NUM_SLOTS-1:0]    = u_if1.ccf;
      end else if (i_paddr == IRQ_STAT_ADDR) begin
         rd_value[NUM_CONV-1:0] = irq_stat_ff;
      end else if (i_paddr == IRQ_MASK_ADDR) begin
         rd_value[NUM_CONV-1:0] = irq_mask_ff;
      end else if (i_paddr[APB_AW-1:RES_WIN_LSB] == RES0_BASE[APB_AW-1:RES_WIN_LSB]) begin
         rd_value[RES_W-1:0] = u_if0.rd_data;
      end else if (i_paddr[APB_AW-1:RES_WIN_LSB] == RES1_BASE[APB_AW-1:RES_WIN_LSB]) begin
         rd_value[RES_W-1:0] = u_if1.rd_data;
      end else begin
         mapped = 1'b0;
      end
   end

   // Bus answer: ready rises one cycle into the access phase
   always_comb begin
      nxt_pready  = i_psel & i_penable & ~pready_ff;
      nxt_prdata  = prdata_ff;
      nxt_pslverr = 1'b0;
      if (i_psel & i_penable & ~pready_ff) begin
         nxt_prdata  = i_pwrite ? '0 : rd_value;
         nxt_pslverr = ~mapped;
      end
   end

   // Interrupt state; a completion in the same cycle as its clear keeps the bit set
   always_comb begin
      nxt_irq_mask = irq_mask_ff;
      nxt_irq_stat = irq_stat_ff;
      if (wr_access & lane0 & (i_paddr == IRQ_MASK_ADDR)) begin
         nxt_irq_mask = i_pwdata[NUM_CONV-1:0];
      end
      if (wr_access & lane0 & (i_paddr == IRQ_STAT_ADDR)) begin
         nxt_irq_stat = irq_stat_ff & ~i_pwdata[NUM_CONV-1:0];
      end
      nxt_irq_stat = nxt_irq_stat | seq_done;
      nxt_irq      = |(nxt_irq_stat & nxt_irq_mask);
   end

   // Bus and interrupt registers
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         prdata_ff   <= '0;
         pready_ff   <= 1'b0;
         pslverr_ff  <= 1'b0;
         irq_stat_ff <= IRQ_RST;
         irq_mask_ff <= IRQ_RST;
         irq_ff      <= 1'b0;
      end else begin
         prdata_ff   <= nxt_prdata;
         pready_ff   <= nxt_pready;
         pslverr_ff  <= nxt_pslverr;
         irq_stat_ff <= nxt_irq_stat;
         irq_mask_ff <= nxt_irq_mask;
         irq_ff      <= nxt_irq;
      end
   end

   assign o_prdata  = prdata_ff;
   assign o_pready  = pready_ff;
   assign o_pslverr = pslverr_ff;
   assign o_irq     = irq_ff;

   // One sequencer per converter; both share the same logic
   asq_sequencer u_seq0 (
      .i_clk     (i_clk),
      .i_sys_rst (i_sys_rst),
      .bus       (u_if0.seq),
      .o_req     (o_conv0_req),
      .o_chan    (o_conv0_chan),
      .i_done    (i_conv0_done),
      .i_data    (i_conv0_data)
   );

   asq_sequencer u_seq1 (
      .i_clk     (i_clk),
      .i_sys_rst (i_sys_rst),
      .bus       (u_if1.seq),
      .o_req     (o_conv1_req),
      .o_chan    (o_conv1_chan),
      .i_done    (i_conv1_done),
      .i_data    (i_conv1_data)
   );

endmodule // asq_top

// [tb/asq_top_chk.sv]
`timescale 1ns/100ps
module asq_top_chk
   import asq_pkg::*;
(
   input wire logic               i_clk,
   input wire logic               i_sys_rst,
   input wire logic               i_psel,
   input wire logic               i_penable,
   input wire logic               i_pwrite,
   input wire logic [APB_AW-1:0]  i_paddr,
   input wire logic [APB_DW-1:0]  i_pwdata,
   input wire logic [3:0]         i_pstrb,
   input wire logic [APB_DW-1:0]  o_prdata,
   input wire logic               o_pready,
   input wire logic               o_pslverr,
   input wire logic               o_irq,
   input wire logic               o_conv0_req,
   input wire logic [CHAN_W-1:0]  o_conv0_chan,
   input wire logic               i_conv0_done,
   input wire logic [RES_W-1:0]   i_conv0_data,
   input wire logic               o_conv1_req,
   input wire logic [CHAN_W-1:0]  o_conv1_chan,
   input wire logic               i_conv1_done,
   input wire logic [RES_W-1:0]   i_conv1_data
);
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_sys_rst);

   // Completed transfers; a write with strobe 0 low is ignored, so it is left out
   logic acc, wr0, wr1;
   assign acc = i_psel && i_penable && o_pready;
   assign wr0 = acc && i_pwrite && i_pstrb[0] && i_paddr == CTL0_ADDR;
   assign wr1 = acc && i_pwrite && i_pstrb[0] && i_paddr == CTL1_ADDR;

   // Bus handshake: exactly one wait state, one-cycle answer
   a_ready_wait: assert property ($rose(i_penable) && i_psel |=> o_pready) else $error("ready late");
   a_ready_pulse: assert property (o_pready |=> !o_pready) else $error("ready held");
   a_ready_cause: assert property (o_pready |-> i_psel && i_penable) else $error("ready outside access");
   a_err_data: assert property (o_pslverr |-> o_pready && o_prdata == '0) else $error("error reply has data");
   // A control write launches a request two edges on, even over a running sequence
   a_start_conv0: assert property (wr0 |-> ##2 o_conv0_req) else $error("no request 0");
   a_start_conv1: assert property (wr1 |-> ##2 o_conv1_req) else $error("no request 1");
   a_ctrl_top_zero:
      assert property (acc && !i_pwrite && (i_paddr == CTL0_ADDR || i_paddr == CTL1_ADDR) |-> o_prdata[31:7] == '0)
      else $error("control upper bits set");
   a_chan_steady: assert property ($changed(o_conv0_chan) |-> o_conv0_req) else $error("channel moved");
   a_req_pulse: assert property (o_conv0_req |=> !o_conv0_req) else $error("request held");

   c_ctrl_write: cover property (wr0);
   c_irq_rise: cover property ($rose(o_irq));
   c_bus_err: cover property (o_pslverr);
endmodule // asq_top_chk

// [tb/tb_asq_top.sv]
`timescale 1ns/100ps
`define CHK(g, x) begin compares++; if ((g) !== (x)) begin err_count++; $display("FAIL t=%0t got=%h exp=%h", $time, g, x); end end
module tb_asq_top;
   import asq_pkg::*;
   logic                i_clk = 0, i_sys_rst = 1, i_psel = 0, i_penable = 0, i_pwrite = 0;
   logic [APB_AW-1:0]   i_paddr = '0;
   logic [APB_DW-1:0]   i_pwdata = '0, o_prdata, q;
   logic [3:0]          i_pstrb = 4'hF;
   logic                o_pready, o_pslverr, o_irq, o_conv0_req, o_conv1_req, e;
   logic [CHAN_W-1:0]   o_conv0_chan, o_conv1_chan;
   logic                i_conv0_done = 0, i_conv1_done = 0;
   logic [RES_W-1:0]    i_conv0_data = '0, i_conv1_data = '0;
   int                  err_count = 0, compares = 0;
   int                  cnt [2] = '{0, 0};
   int                  reqs [2] = '{0, 0};

   asq_top dut_u (.*);

   always #20 i_clk = ~i_clk;

   // Converter stand-in: answers three cycles after a request, result tags the channel used
   always @(posedge i_clk) begin
      i_conv0_done <= (cnt[0] == 1);
      i_conv1_done <= (cnt[1] == 1);
      i_conv0_data <= {6'h15, o_conv0_chan};
      i_conv1_data <= {6'h15, o_conv1_chan};
      cnt[0] <= o_conv0_req ? 3 : (cnt[0] > 0 ? cnt[0] - 1 : 0);
      cnt[1] <= o_conv1_req ? 3 : (cnt[1] > 0 ? cnt[1] - 1 : 0);
      reqs[0] <= reqs[0] + o_conv0_req;
      reqs[1] <= reqs[1] + o_conv1_req;
   end

   task automatic wrap_up();
      $display("Comparisons %0d, mismatches %0d", compares, err_count);
      if (err_count == 0 && compares > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   // One transfer; request held until ready is sampled, then one idle edge
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      i_psel <= 1; i_pwrite <= w; i_paddr <= a; i_pwdata <= d;
      @(posedge i_clk) i_penable <= 1;
      n = 0;
      do begin @(posedge i_clk); n++; end while (o_pready !== 1'b1 && n < 20);
      q = o_prdata;
      e = o_pslverr;
      i_psel <= 0; i_penable <= 0;
      @(posedge i_clk);
      if (n >= 20) begin err_count++; wrap_up(); end
   endtask

   task automatic rd(input logic [11:0] a, input logic [31:0] x);
      apb(0, a, 0);
      `CHK(q, x)
   endtask

   // Poll the status word until the sequence flag shows, bounded
   task automatic wait_seq(input int k);
      int n;
      n = 0;
      do begin apb(0, k ? STAT1_ADDR : STAT0_ADDR, 0); n++; end while (q[STAT_SEQ_BIT] !== 1'b1 && n < 40);
      if (n >= 40) begin err_count++; wrap_up(); end
   endtask

   task automatic t_regs();
      rd(CTL0_ADDR, 0);
      rd(CTL1_ADDR, 0);
      i_pstrb <= 4'h0;
      apb(1, CTL0_ADDR, 32'h55);
      i_pstrb <= 4'hF;
      rd(CTL0_ADDR, 0);
      apb(0, 12'h7F0, 0);
      `CHK(e, 1'b1)
      apb(1, CTL0_ADDR, 32'hFF);
      rd(CTL0_ADDR, 32'h7F);
      apb(1, CTL0_ADDR, 32'h00);
      wait_seq(0);
      $display("Register test done");
   endtask

   task automatic t_seq(input int k, input logic [6:0] c);
      int r, m;
      logic [3:0] ch;
      m = c[CTL_EIGHT_BIT] ? 8 : 4;
      r = reqs[k];
      apb(1, k ? CTL1_ADDR : CTL0_ADDR, {25'h0, c});
      wait_seq(k);
      `CHK(q[8:0], {1'b1, 8'(2 ** m - 1)})
      repeat (10) @(posedge i_clk);
      `CHK(reqs[k] - r, m)
      for (int s = 0; s < m; s++) begin
         ch = !c[CTL_MULTICHANNEL_ENABLE_BIT] ? c[3:0] : (m == 8 ? {c[3], 3'(s)} : {c[3:2], 2'(s)});
         apb(0, (k ? RES1_BASE : RES0_BASE) + 12'(4 * s), 0);
         `CHK(q, {22'h0, 6'h15, ch})
      end
      $display("Sequence test done, control %h", c);
   endtask

   task automatic t_irq();
      // Earlier sequences on both converters left their status bits set; start clean
      apb(1, IRQ_STAT_ADDR, 3);
      rd(IRQ_STAT_ADDR, 0);
      apb(1, IRQ_MASK_ADDR, 1);
      `CHK(o_irq, 1'b0)
      t_seq(0, 7'h10);
      `CHK(o_irq, 1'b1)
      apb(1, STAT0_ADDR, 0);
      rd(STAT0_ADDR, 32'h10F);
      rd(IRQ_STAT_ADDR, 1);
      apb(1, IRQ_STAT_ADDR, 1);
      `CHK(o_irq, 1'b0)
      apb(1, IRQ_MASK_ADDR, 0);
      t_seq(1, 7'h10);
      `CHK(o_irq, 1'b0)
      rd(IRQ_STAT_ADDR, 2);
      apb(1, IRQ_STAT_ADDR, 3);
      $display("Interrupt test done");
   endtask

   // Scan repeats on its own; a write in mid-scan clears the old flags at once
   task automatic t_scan();
      int r, n;
      r = reqs[0];
      apb(1, CTL0_ADDR, 32'h23);
      n = 0;
      while (reqs[0] - r < 10 && n < 200) begin @(posedge i_clk); n++; end
      `CHK(n < 200, 1'b1)
      apb(1, CTL0_ADDR, 32'h01);
      rd(STAT0_ADDR, 0);
      wait_seq(0);
      $display("Scan test done");
   endtask

   // Group two in four-conversion multichannel mode is never picked
   logic [6:0] tbl [7] = '{7'h05, 7'h45, 7'h10, 7'h14, 7'h1C, 7'h50, 7'h58};

   initial begin
      repeat (10) @(posedge i_clk);
      i_sys_rst <= 0;
      @(posedge i_clk);
      t_regs();
      for (int i = 0; i < 7; i++) t_seq(i % 2, tbl[i]);
      t_irq();
      t_scan();
      wrap_up();
   end
endmodule // tb_asq_top

bind asq_top asq_top_chk chk_u (.*);
